// ### inc/rrc_pkg.sv
package rrc_pkg;
  // Timing
  localparam int CLK_KHZ = 125000;
  localparam int DETECT_MS = 20;
  localparam int WIN_US = 1000;
  localparam int WIN_CYC = CLK_KHZ * WIN_US / 1000;
  localparam int STABLE_WIN = DETECT_MS * 1000 / WIN_US;
  localparam int FRAME_KHZ = 8;
  localparam int FRAME_CYC = CLK_KHZ / FRAME_KHZ;
  localparam int SKEW_STEP_PS = 250;
  localparam int SKEW_MAX_PS = 32000;
  localparam int BOOT_CYC = 2;

  // Register offsets
  localparam logic [7:0] ADDR_OP = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h01;
  localparam logic [7:0] ADDR_XSKEW = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_OUT_RATE = 8'h04;
  localparam logic [7:0] ADDR_CFG_DATA = 8'h05;
  localparam logic [7:0] ADDR_REF_BASE = 8'h10;

  // Reset values
  localparam logic [3:0] OP_RST = 4'h8;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] XSKEW_RST = 8'h00;
  localparam logic [3:0] RANK_RST = 4'hF;

  // Field positions
  localparam int OP_AUTO_BIT = 3;
  localparam int RANK_LSB = 4;
  localparam int ST_MASTER = 0;
  localparam int ST_REG_MODE = 1;
  localparam int ST_CFG_SRC = 2;
  localparam int ST_REF_OK = 3;
  localparam int ST_ACT_LSB = 4;

  // Rate codes: code n means count passed the first n bounds
  localparam logic [3:0] RATE_NONE = 4'h0;
  localparam int RATE_BOUNDS = 10;
  localparam int RATE_BOUND_KHZ [RATE_BOUNDS] = '{4, 800, 1800, 7500, 16200, 22680, 32400, 45360, 64800, 116640};
endpackage

// ### rtl/rrc_ctrl.sv
// Function
// - Detect which synchronized clock output rate the oscillator delivers, 12.96 to 155.52 MHz.
// - Accept up to eight reference inputs, each 8 kHz through 77.76 MHz.
// - Measure each reference rate and report it in its rate/rank register.
// - A changed reference rate needs 20 ms to detect; avoid manual selection meanwhile.
// - Automatic selection only picks references whose rate has settled.
// - Every active reference change is hitless via a phase build-out request.
// - Slave aligns its 8 kHz frame to the mate's frame output on cross-reference.
// - Slave turning master performs a phase build-out against its reference.
// - Outputs offset from cross-reference by programmed skew, 0.25 ns steps, up to 32 ns.
// - Role follows only the master/slave select pin, never changes by itself.
// - A promoted slave keeps the selection taken from its operational mode setting.
// - Reset returns all internal logic and registers to defaults.
// - After reset, mode and functions come from the hardware control pins.
// - Configuration data from serial memory, or loaded by host over the bus.
// - Configuration source pin: 0 loads over the bus, 1 from serial memory.
module rrc_ctrl #(
  parameter int N_REF = 8,
  parameter int WIN_CYC = rrc_pkg::WIN_CYC,
  parameter int FRAME_CYC = rrc_pkg::FRAME_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [N_REF-1:0] ref_in,
  input wire logic sync_clk_in,
  input wire logic xref_in,
  input wire logic ms_sel_in,
  input wire logic ctl_reg_mode_in,
  input wire logic cfg_src_in,
  input wire logic [2:0] hw_ref_sel_in,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [2:0] active_ref,
  output logic ref_ok,
  output logic is_master,
  output logic phase_buildout,
  output logic [7:0] phase_offset,
  output logic frame_8k_output,
  output logic cfg_from_eeprom,
  output logic cfg_wr_strobe,
  output logic [7:0] cfg_wr_data
);
  localparam int STABLE_WIN = rrc_pkg::STABLE_WIN;

  initial begin
    if (N_REF < 1 || N_REF > 8) $error("N_REF must be 1 to 8");
    if (WIN_CYC < 2 || WIN_CYC >= (1 << 23)) $error("WIN_CYC out of range");
    if (FRAME_CYC < 2 || FRAME_CYC >= (1 << 16)) $error("FRAME_CYC out of range");
  end

  typedef struct packed {
    logic [N_REF-1:0] ref_s1;
    logic [N_REF-1:0] ref_s2;
    logic [N_REF-1:0] ref_s3;
    logic [2:0] sclk_s;
    logic [2:0] xref_s;
    logic [1:0] ms_s;
    logic [1:0] ctl_s;
    logic [1:0] cfg_s;
    logic [2:0] hws1;
    logic [2:0] hws2;
    logic [1:0] boot;
    logic reg_mode;
    logic cfg_src;
    logic master;
    logic [23:0] win;
    logic [N_REF-1:0][23:0] cnt;
    logic [N_REF-1:0][3:0] rate;
    logic [N_REF-1:0][4:0] stab;
    logic [N_REF-1:0][3:0] rank;
    logic [23:0] out_cnt;
    logic [3:0] out_rate;
    logic [3:0] op;
    logic [7:0] mask;
    logic [7:0] xskew;
    logic [2:0] sel;
    logic ok;
    logic pbo;
    logic [7:0] poff;
    logic [15:0] frm;
    logic frame;
    logic cfg_stb;
    logic [7:0] cfg_data;
    logic [7:0] rdata;
  } rrc_state_s;

  rrc_state_s q;
  rrc_state_s d;
  logic [N_REF-1:0] qual;
  logic [N_REF-1:0] ref_edge;
  logic xref_edge;

  function automatic logic [3:0] rate_of(input logic [23:0] cnt);
    logic [3:0] code;
    logic [47:0] scaled;
    code = rrc_pkg::RATE_NONE;
    scaled = 48'(cnt) * 48'(rrc_pkg::CLK_KHZ);
    for (int b = 0; b < rrc_pkg::RATE_BOUNDS; b++) begin
      if (scaled >= 48'(rrc_pkg::RATE_BOUND_KHZ[b]) * 48'(WIN_CYC)) code = 4'(b + 1);
    end
    return code;
  endfunction

  // qualified once rate held for the detect interval
  always_comb begin
    for (int i = 0; i < N_REF; i++) begin
      qual[i] = (q.stab[i] == 5'(STABLE_WIN)) && (q.rate[i] != rrc_pkg::RATE_NONE);
    end
  end

  assign ref_edge = q.ref_s2 & ~q.ref_s3;
  assign xref_edge = q.xref_s[1] & ~q.xref_s[2];

  always_comb begin
    logic [3:0] best_rank;
    logic [2:0] pick;
    logic found;
    logic [3:0] r;
    best_rank = 4'hF;
    pick = 3'h0;
    found = 1'b0;
    r = 4'h0;
    d = q;
    d.ref_s1 = ref_in;
    d.ref_s2 = q.ref_s1;
    d.ref_s3 = q.ref_s2;
    d.sclk_s = {q.sclk_s[1:0], sync_clk_in};
    d.xref_s = {q.xref_s[1:0], xref_in};
    d.ms_s = {q.ms_s[0], ms_sel_in};
    d.ctl_s = {q.ctl_s[0], ctl_reg_mode_in};
    d.cfg_s = {q.cfg_s[0], cfg_src_in};
    d.hws1 = hw_ref_sel_in;
    d.hws2 = q.hws1;
    d.pbo = 1'b0;
    d.cfg_stb = 1'b0;
    d.rdata = 8'h00;

    // control straps caught once the synchronizers have filled
    if (q.boot != 2'(rrc_pkg::BOOT_CYC + 1)) d.boot = q.boot + 2'h1;
    if (q.boot == 2'(rrc_pkg::BOOT_CYC)) begin
      d.reg_mode = q.ctl_s[1];
      d.cfg_src = q.cfg_s[1];
    end

    // role only from the synchronized select pin
    d.master = q.ms_s[1];

    // count reference edges over the gate window
    if (q.win == 24'(WIN_CYC - 1)) begin
      d.win = 24'h00_0000;
      for (int i = 0; i < N_REF; i++) begin
        r = rate_of(q.cnt[i]);
        d.cnt[i] = {23'h00_0000, ref_edge[i]};
        d.rate[i] = r;
        // detection restarts the 20 ms settle on any change
        if (r != q.rate[i]) d.stab[i] = 5'h00;
        else if (q.stab[i] != 5'(STABLE_WIN)) d.stab[i] = q.stab[i] + 5'h01;
      end
      d.out_rate = rate_of(q.out_cnt);
      d.out_cnt = {23'h00_0000, q.sclk_s[1] & ~q.sclk_s[2]};
    end else begin
      d.win = q.win + 24'h00_0001;
      for (int i = 0; i < N_REF; i++) begin
        d.cnt[i] = q.cnt[i] + {23'h00_0000, ref_edge[i]};
      end
      d.out_cnt = q.out_cnt + {23'h00_0000, q.sclk_s[1] & ~q.sclk_s[2]};
    end

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        rrc_pkg::ADDR_OP: d.op = reg_wdata[3:0];
        rrc_pkg::ADDR_MASK: d.mask = reg_wdata;
        rrc_pkg::ADDR_XSKEW: d.xskew = reg_wdata;
        rrc_pkg::ADDR_CFG_DATA: begin
          // bus load only when the source pin selects the bus
          if (!q.cfg_src && q.boot == 2'(rrc_pkg::BOOT_CYC + 1)) begin
            d.cfg_stb = 1'b1;
            d.cfg_data = reg_wdata;
          end
        end
        default: begin
          if (reg_addr[7:3] == rrc_pkg::ADDR_REF_BASE[7:3] && 32'(reg_addr[2:0]) < N_REF) begin
            d.rank[reg_addr[2:0]] = reg_wdata[7:rrc_pkg::RANK_LSB];
          end
        end
      endcase
    end

    // Register reads, data stands one cycle later
    if (reg_rd) begin
      unique case (reg_addr)
        rrc_pkg::ADDR_OP: d.rdata = {4'h0, q.op};
        rrc_pkg::ADDR_MASK: d.rdata = q.mask;
        rrc_pkg::ADDR_XSKEW: d.rdata = q.xskew;
        rrc_pkg::ADDR_STATUS: begin
          d.rdata[rrc_pkg::ST_MASTER] = q.master;
          d.rdata[rrc_pkg::ST_REG_MODE] = q.reg_mode;
          d.rdata[rrc_pkg::ST_CFG_SRC] = q.cfg_src;
          d.rdata[rrc_pkg::ST_REF_OK] = q.ok;
          d.rdata[rrc_pkg::ST_ACT_LSB +: 3] = q.sel;
        end
        rrc_pkg::ADDR_OUT_RATE: d.rdata = {4'h0, q.out_rate};
        default: begin
          if (reg_addr[7:3] == rrc_pkg::ADDR_REF_BASE[7:3] && 32'(reg_addr[2:0]) < N_REF) begin
            d.rdata = {q.rank[reg_addr[2:0]], q.rate[reg_addr[2:0]]};
          end
        end
      endcase
    end

    // automatic pick of best-ranked settled, enabled reference
    if (q.reg_mode && q.op[rrc_pkg::OP_AUTO_BIT]) begin
      for (int i = 0; i < N_REF; i++) begin
        if (qual[i] && !q.mask[i] && (!found || q.rank[i] < best_rank)) begin
          found = 1'b1;
          best_rank = q.rank[i];
          pick = 3'(i);
        end
      end
      // Nothing usable: stay on the last reference
      d.sel = found ? pick : q.sel;
    end else if (q.reg_mode) begin
      // selection carried in the operational mode setting
      d.sel = q.op[2:0];
    end else begin
      d.sel = q.hws2;
    end
    d.ok = qual[d.sel];

    // selection change requests a phase build-out
    if (d.sel != q.sel) d.pbo = 1'b1;
    // build-out on slave to master promotion
    if (d.master && !q.master) d.pbo = 1'b1;

    // programmed skew applies while slaved to cross-reference
    d.poff = d.master ? 8'h00 : d.xskew;

    // slave frame counter restarts on mate's frame edge
    if (!q.master && xref_edge) d.frm = 16'h0000;
    else if (q.frm == 16'(FRAME_CYC - 1)) d.frm = 16'h0000;
    else d.frm = q.frm + 16'h0001;
    d.frame = (d.frm == 16'h0000);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.op <= rrc_pkg::OP_RST;
      q.mask <= rrc_pkg::MASK_RST;
      q.xskew <= rrc_pkg::XSKEW_RST;
      for (int i = 0; i < N_REF; i++) q.rank[i] <= rrc_pkg::RANK_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign active_ref = q.sel;
  assign ref_ok = q.ok;
  assign is_master = q.master;
  assign phase_buildout = q.pbo;
  assign phase_offset = q.poff;
  assign frame_8k_output = q.frame;
  // serial memory path chosen by the strap
  assign cfg_from_eeprom = q.cfg_src;
  assign cfg_wr_strobe = q.cfg_stb;
  assign cfg_wr_data = q.cfg_data;

  a_role_pin: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst, 1) && !$past(sys_rst, 2) && !$past(sys_rst, 3) |-> is_master == $past(ms_sel_in, 3))
    else $error("role does not follow select pin");
  a_promote_pbo: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && $rose(is_master) |-> phase_buildout)
    else $error("no build-out on promotion");
  a_switch_hitless: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && $changed(active_ref) |-> phase_buildout)
    else $error("reference change without build-out");
  a_auto_settled: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && $past(q.reg_mode && q.op[3]) && $changed(active_ref)
    |-> ref_ok && $past(q.stab[d.sel] == 5'(STABLE_WIN)))
    else $error("unsettled reference picked");
  a_skew_slave: assert property (@(posedge clk) disable iff (sys_rst)
    phase_offset == (is_master ? 8'h00 : q.xskew))
    else $error("phase offset wrong for role");
  a_frame_align: assert property (@(posedge clk) disable iff (sys_rst)
    !q.master && xref_edge |=> frame_8k_output)
    else $error("slave frame not aligned to cross-reference");
  a_cfg_source: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_wr_strobe |-> !cfg_from_eeprom)
    else $error("bus config write while memory selected");
  a_cfg_write: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == rrc_pkg::ADDR_CFG_DATA && !q.cfg_src && q.boot == 2'h3
    |=> cfg_wr_strobe && cfg_wr_data == $past(reg_wdata))
    else $error("config write lost");
  a_rate_read: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == rrc_pkg::ADDR_REF_BASE |=> reg_rdata[3:0] == $past(q.rate[0]))
    else $error("rate register misreports");
  a_manual_sel: assert property (@(posedge clk) disable iff (sys_rst)
    q.reg_mode && !q.op[3] |=> active_ref == $past(q.op[2:0]))
    else $error("manual selection not taken");
  a_reset_dflt: assert property (@(posedge clk)
    $past(sys_rst) && !sys_rst |-> q.op == rrc_pkg::OP_RST && q.mask == 8'h00 && !cfg_wr_strobe && !phase_buildout)
    else $error("defaults not restored");

  c_promote: cover property (@(posedge clk) disable iff (sys_rst) $rose(is_master));
  c_auto_switch: cover property (@(posedge clk) disable iff (sys_rst) q.op[3] && $changed(active_ref));
  c_cfg_load: cover property (@(posedge clk) disable iff (sys_rst) cfg_wr_strobe);
  c_slave_frame: cover property (@(posedge clk) disable iff (sys_rst) !is_master && frame_8k_output);
endmodule

// ### test/rrc_mate.sv
module rrc_mate #(
  parameter int XREF_NS = 512
) (
  output logic [7:0] ref_in,
  output logic sync_clk_in,
  output logic xref_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ref_in = 8'h00;
    sync_clk_in = 1'b0;
    xref_in = 1'b0;
  end
  always #244.140 ref_in[0] = ~ref_in[0];
  always #25.720 ref_in[1] = ~ref_in[1];
  always #12.860 sync_clk_in = ~sync_clk_in;
  always begin
    #(XREF_NS - 40) xref_in = 1'b1;
    #40 xref_in = 1'b0;
  end
endmodule

// ### test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, ms_sel_in = 0, ctl_reg_mode_in = 0, cfg_src_in = 1, reg_wr = 0, reg_rd = 0;
  logic [2:0] hw_ref_sel_in = 3'h2;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, phase_offset, cfg_wr_data, ref_in, v;
  logic [2:0] active_ref;
  logic ref_ok, is_master, phase_buildout, frame_8k_output, cfg_from_eeprom, cfg_wr_strobe, sync_clk_in, xref_in;
  int miscompares = 0;
  int cmp_count = 0;
  rrc_mate u_mate (.ref_in(ref_in), .sync_clk_in(sync_clk_in), .xref_in(xref_in));
  rrc_ctrl #(.N_REF(8), .WIN_CYC(1250), .FRAME_CYC(64)) dut (.clk(clk), .sys_rst(sys_rst), .ref_in(ref_in),
    .sync_clk_in(sync_clk_in), .xref_in(xref_in), .ms_sel_in(ms_sel_in), .ctl_reg_mode_in(ctl_reg_mode_in),
    .cfg_src_in(cfg_src_in), .hw_ref_sel_in(hw_ref_sel_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .active_ref(active_ref), .ref_ok(ref_ok),
    .is_master(is_master), .phase_buildout(phase_buildout), .phase_offset(phase_offset),
    .frame_8k_output(frame_8k_output), .cfg_from_eeprom(cfg_from_eeprom), .cfg_wr_strobe(cfg_wr_strobe),
    .cfg_wr_data(cfg_wr_data));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic do_reset(input logic reg_mode, input logic cfg_src);
    @(posedge clk);
    sys_rst <= 1'b1;
    ctl_reg_mode_in <= reg_mode;
    cfg_src_in <= cfg_src;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(6);
  endtask
  // Waits for a new selection and expects the build-out pulse with it
  task automatic wait_ref(input logic [2:0] exp);
    int n;
    for (n = 0; n < 20 && active_ref !== exp; n++) cyc(1);
    chk("active_ref", {5'h00, exp}, {5'h00, active_ref});
    chk("phase_buildout", 8'h01, {7'h00, phase_buildout});
  endtask
  task automatic t_hw_straps;
    logic seen;
    do_reset(1'b0, 1'b1);
    chk("cfg_from_eeprom", 8'h01, {7'h00, cfg_from_eeprom});
    chk("hw active_ref", 8'h02, {5'h00, active_ref});
    hw_ref_sel_in <= 3'h5;
    cyc(4);
    chk("hw active_ref", 8'h05, {5'h00, active_ref});
    wr(8'h05, 8'h3C);
    seen = cfg_wr_strobe;
    cyc(1);
    chk("cfg strobe ignored", 8'h00, {7'h00, seen | cfg_wr_strobe});
  endtask
  task automatic t_reset_regs;
    logic seen;
    do_reset(1'b1, 1'b0);
    rd(8'h00, v);
    chk("op", 8'h08, v);
    rd(8'h01, v);
    chk("mask", 8'h00, v);
    rd(8'h02, v);
    chk("xskew", 8'h00, v);
    rd(8'h17, v);
    chk("rank7", 8'hF0, v & 8'hF0);
    rd(8'h20, v);
    chk("unmapped", 8'h00, v);
    wr(8'h05, 8'h5A);
    seen = cfg_wr_strobe;
    chk("cfg strobe", 8'h01, {7'h00, seen});
    chk("cfg data", 8'h5A, cfg_wr_data);
    cyc(1);
    chk("cfg strobe pulse", 8'h00, {7'h00, cfg_wr_strobe});
  endtask
  task automatic t_rates;
    cyc(30 * 1250);
    rd(8'h10, v);
    chk("ref0 rate", 8'h03, v & 8'h0F);
    rd(8'h11, v);
    chk("ref1 rate", 8'h05, v & 8'h0F);
    rd(8'h12, v);
    chk("ref2 rate", 8'h00, v & 8'h0F);
    rd(8'h04, v);
    chk("out rate", 8'h07, v);
    rd(8'h03, v);
    chk("status", 8'h0A, v);
    chk("ref_ok", 8'h01, {7'h00, ref_ok});
  endtask
  task automatic t_auto_select;
    // ref2 ranked 0 and ref1 ranked 1; ref2 carries no signal, so ref1 is picked
    wr(8'h12, 8'h00);
    wr(8'h11, 8'h10);
    wait_ref(3'h1);
    wr(8'h01, 8'h02);
    wait_ref(3'h0);
    wr(8'h01, 8'h00);
    wait_ref(3'h1);
  endtask
  task automatic t_manual;
    wr(8'h00, 8'h02);
    cyc(1);
    chk("manual ref", 8'h02, {5'h00, active_ref});
    chk("manual buildout", 8'h01, {7'h00, phase_buildout});
    wr(8'h00, 8'h01);
    cyc(1);
    chk("manual ref", 8'h01, {5'h00, active_ref});
  endtask
  task automatic t_frame;
    int n;
    for (n = 0; n < 200 && xref_in !== 1'b0; n++) cyc(1);
    for (n = 0; n < 200 && xref_in !== 1'b1; n++) cyc(1);
    for (n = 0; n < 8 && frame_8k_output !== 1'b1; n++) cyc(1);
    chk("frame delay ok", 8'h01, {7'h00, n >= 2 && n <= 3});
  endtask
  task automatic t_role;
    int n;
    wr(8'h02, 8'h80);
    cyc(1);
    chk("phase_offset", 8'h80, phase_offset);
    chk("is_master", 8'h00, {7'h00, is_master});
    wr(8'h00, 8'h01);
    // role switched by one select line
    ms_sel_in <= 1'b1;
    for (n = 0; n < 6 && is_master !== 1'b1; n++) cyc(1);
    chk("role delay ok", 8'h01, {7'h00, n >= 2 && n <= 4});
    chk("promote buildout", 8'h01, {7'h00, phase_buildout});
    cyc(2);
    chk("master offset", 8'h00, phase_offset);
    chk("kept ref", 8'h01, {5'h00, active_ref});
    cyc(200);
    chk("is_master held", 8'h01, {7'h00, is_master});
  endtask
  task automatic close_out;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #600_000;
    miscompares++;
    close_out();
  end
  initial begin
    t_hw_straps();
    t_reset_regs();
    t_rates();
    t_auto_select();
    t_manual();
    t_frame();
    t_role();
    close_out();
  end
endmodule
